// [src/simsample_adc_conv_parallel_read.sv]
// conversion sequencing, power-down selection, sample fifo and parallel readout
`timescale 1ns/100ps

// ****************************************************************
// sample fifo between the converter core and the output register
// ****************************************************************
module sample_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule : sample_fifo

// ****************************************************************
// converter control top
// ****************************************************************
module simsample_adc_conv_parallel_read #(
  parameter int CONV_COUNT = simsample_pkg::CONV_CYCLES,
  parameter int WAKE_COUNT = simsample_pkg::WAKE_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // power control pins
  input wire logic low_power_request_n,
  input wire logic range_select,
  // sample triggers
  input wire logic sample_trigger_a,
  input wire logic sample_trigger_b,
  // interface straps
  input wire logic interface_select,
  input wire logic byte_mode_select,
  // readout control pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  // converter core samples, one per channel, twos complement
  input wire logic [simsample_pkg::NUM_CHANNELS*simsample_pkg::RESULT_BITS-1:0] core_samples,
  // status
  output logic busy,
  output logic [7:0] hold_channels,
  output simsample_pkg::power_mode_t power_mode,
  output logic parallel_mode,
  output logic serial_mode,
  output logic byte_mode,
  // parallel data bus
  output logic [simsample_pkg::BUS_BITS-1:0] parallel_data_out,
  output logic parallel_data_oe
);
  import simsample_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [6:0] pin_meta_ff;
  logic [6:0] pin_sync_ff;
  logic trig_a_prev_ff;
  logic trig_b_prev_ff;
  logic rd_prev_ff;
  logic cs_prev_ff;
  logic trig_a_s, trig_b_s, lpr_n_s, range_s, cs_n_s, rd_n_s;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_meta_ff <= 7'h7f;
      pin_sync_ff <= 7'h7f;
    end else begin
      pin_meta_ff <= {sample_trigger_a, sample_trigger_b, low_power_request_n,
                      range_select, chip_select_n, read_strobe_n, 1'b1};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign trig_a_s = pin_sync_ff[6];
  assign trig_b_s = pin_sync_ff[5];
  assign lpr_n_s = pin_sync_ff[4];
  assign range_s = pin_sync_ff[3];
  assign cs_n_s = pin_sync_ff[2];
  assign rd_n_s = pin_sync_ff[1];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trig_a_prev_ff <= 1'b1;
      trig_b_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
    end else begin
      trig_a_prev_ff <= trig_a_s;
      trig_b_prev_ff <= trig_b_s;
      rd_prev_ff <= rd_n_s;
      cs_prev_ff <= cs_n_s;
    end
  end

  logic rise_a, rise_b, rd_fall;
  assign rise_a = trig_a_s && !trig_a_prev_ff;
  assign rise_b = trig_b_s && !trig_b_prev_ff;
  assign rd_fall = !rd_n_s && rd_prev_ff && !cs_n_s;

  // ****************************************************************
  // straps, sampled on every clock while reset is held, kept after reset release
  // ****************************************************************
  logic [1:0] strap_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strap_ff <= {interface_select, byte_mode_select};
    end
  end
  assign parallel_mode = (strap_ff == IF_PARALLEL);
  assign serial_mode = (strap_ff == IF_SERIAL);
  assign byte_mode = (strap_ff == IF_BYTE);

  // ****************************************************************
  // power mode
  // ****************************************************************
  power_mode_t nxt_power;
  always_comb begin
    if (lpr_n_s) begin
      nxt_power = PWR_NORMAL;
    end else if (range_s) begin
      nxt_power = PWR_STANDBY;
    end else begin
      nxt_power = PWR_SHUTDOWN;
    end
  end
  assign power_mode = nxt_power;

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  conv_state_t state_ff;
  logic [31:0] timer_ff;
  logic held_a_ff;
  logic held_b_ff;
  logic conv_done;
  logic both_held;
  logic start_conv;

  assign both_held = (held_a_ff || rise_a) && (held_b_ff || rise_b);
  // loading must follow the very same start as the sequencer, or the fifo drifts out of step
  assign start_conv = (state_ff == ST_IDLE) && (nxt_power == PWR_NORMAL) && both_held;
  assign conv_done = (state_ff == ST_CONV) && (timer_ff == 32'(CONV_COUNT - 1));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      timer_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          timer_ff <= '0;
          if (nxt_power != PWR_NORMAL) begin
            state_ff <= ST_DOWN;
          end else if (both_held) begin
            state_ff <= ST_CONV;
          end
        end
        ST_CONV: begin
          timer_ff <= timer_ff + 32'h0000_0001;
          if (conv_done) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_DOWN: begin
          timer_ff <= '0;
          if (nxt_power == PWR_NORMAL) begin
            state_ff <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          timer_ff <= timer_ff + 32'h0000_0001;
          if (nxt_power != PWR_NORMAL) begin
            state_ff <= ST_DOWN;
          end else if (timer_ff == 32'(WAKE_COUNT - 1)) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_ff == ST_CONV);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      held_a_ff <= 1'b0;
      held_b_ff <= 1'b0;
    end else if (conv_done || state_ff != ST_IDLE) begin
      held_a_ff <= (state_ff == ST_CONV) && !conv_done;
      held_b_ff <= (state_ff == ST_CONV) && !conv_done;
    end else begin
      held_a_ff <= held_a_ff || rise_a;
      held_b_ff <= held_b_ff || rise_b;
    end
  end
  assign hold_channels = {{4{held_b_ff}}, {4{held_a_ff}}};

  // ****************************************************************
  // sampling into fifo, then publish at busy fall
  // ****************************************************************
  logic [RESULT_BITS-1:0] hold_ff [NUM_CHANNELS];
  logic [3:0] load_idx_ff;
  logic loading_ff;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [RESULT_BITS-1:0] fifo_out_data;

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if ((i < 4 && rise_a && !held_a_ff) || (i >= 4 && rise_b && !held_b_ff)) begin
        hold_ff[i] <= core_samples[i*RESULT_BITS +: RESULT_BITS];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      loading_ff <= 1'b0;
      load_idx_ff <= SPLIT_FIRST;
    end else if (start_conv) begin
      loading_ff <= 1'b1;
      load_idx_ff <= SPLIT_FIRST;
    end else if (loading_ff && fifo_in_ready) begin
      load_idx_ff <= load_idx_ff + 4'h1;
      loading_ff <= (load_idx_ff != {1'b0, CHAN_LAST});
    end
  end

  sample_fifo #(.WIDTH(RESULT_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(loading_ff),
    .in_ready(fifo_in_ready),
    .in_data(hold_ff[load_idx_ff[2:0]]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  logic publishing_ff;
  logic [3:0] pub_idx_ff;
  logic [RESULT_BITS-1:0] result_ff [NUM_CHANNELS];
  assign fifo_out_ready = publishing_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      publishing_ff <= 1'b0;
      pub_idx_ff <= SPLIT_FIRST;
    end else if (conv_done) begin
      publishing_ff <= 1'b1;
      pub_idx_ff <= SPLIT_FIRST;
    end else if (publishing_ff && fifo_out_valid) begin
      pub_idx_ff <= pub_idx_ff + 4'h1;
      publishing_ff <= (pub_idx_ff != {1'b0, CHAN_LAST});
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        result_ff[i] <= '0;
      end
    end else if (publishing_ff && fifo_out_valid) begin
      result_ff[pub_idx_ff[2:0]] <= fifo_out_data;
    end
  end

  // ****************************************************************
  // parallel readout
  // ****************************************************************
  logic [CHAN_IDX_BITS-1:0] rd_chan_ff;
  logic [BUS_BITS-1:0] data_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst || conv_done) begin
      rd_chan_ff <= CHAN_FIRST;
    end else if (rd_fall) begin
      rd_chan_ff <= rd_chan_ff + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_ff <= '0;
    end else if (rd_fall) begin
      data_ff <= {{2{result_ff[rd_chan_ff][SIGN_BIT]}}, result_ff[rd_chan_ff]};
    end
  end
  assign parallel_data_out = data_ff;

  assign parallel_data_oe = parallel_mode && !cs_n_s && !rd_n_s && (state_ff != ST_DOWN);

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [31:0] busy_len_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst || !busy) begin
      busy_len_ff <= '0;
    end else begin
      busy_len_ff <= busy_len_ff + 32'h0000_0001;
    end
  end

  a_busy_length: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(busy) |-> $past(busy_len_ff) == 32'(CONV_COUNT - 1))
    else $error("busy width wrong");
  a_busy_start: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_ff == ST_IDLE && both_held && nxt_power == PWR_NORMAL) |=> busy)
    else $error("busy did not rise on later trigger");
  a_oe_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    parallel_data_oe |-> (!cs_n_s && !rd_n_s))
    else $error("bus driven without select and strobe");
  a_cs_release: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(cs_n_s) |-> !parallel_data_oe)
    else $error("bus not released on select rise");
  a_sign_copy: assert property (@(posedge mclk) disable iff (sys_rst)
    data_ff[15] == data_ff[13] && data_ff[14] == data_ff[13])
    else $error("sign extension broken");
  a_chan_first: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(busy) |-> rd_chan_ff == CHAN_FIRST)
    else $error("channel pointer not reset at busy fall");
  a_chan_step: assert property (@(posedge mclk) disable iff (sys_rst)
    (rd_fall && !conv_done) |=> rd_chan_ff == $past(rd_chan_ff) + 3'h1)
    else $error("channel pointer did not advance");
  a_power_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    (!lpr_n_s && !range_s) |-> power_mode == PWR_SHUTDOWN)
    else $error("shutdown not selected");
  a_publish_done: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(busy) |-> ##[1:12] !publishing_ff)
    else $error("results not published after busy fall");
  a_hold_split: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_ff == ST_IDLE && rise_a && !held_a_ff && !both_held) |=> held_a_ff && !held_b_ff)
    else $error("split hold wrong");

  c_common_conv: cover property (@(posedge mclk) rise_a && rise_b && state_ff == ST_IDLE);
  c_split_conv: cover property (@(posedge mclk) held_a_ff && !held_b_ff ##[1:50] busy);
  c_read_eight: cover property (@(posedge mclk) rd_fall && rd_chan_ff == CHAN_LAST);
  c_wake: cover property (@(posedge mclk) state_ff == ST_WAKE ##1 state_ff == ST_IDLE);
endmodule : simsample_adc_conv_parallel_read

// [src/simsample_pkg.sv]
// shared constants for the simultaneous-sampling converter control block
package simsample_pkg;
  localparam int CLK_MHZ = 250;
  localparam int NUM_CHANNELS = 8;
  localparam int RESULT_BITS = 14;
  localparam int BUS_BITS = 16;
  localparam int CHAN_IDX_BITS = 3;
  // conversion time, ns, and its count of cycles (longest time rounds down)
  localparam int CONVERSION_TIME_NS = 4000;
  localparam int CONV_CYCLES = (CONVERSION_TIME_NS * CLK_MHZ) / 1000;
  // standby wake time, us, and its count of cycles (least time rounds up)
  localparam int STANDBY_WAKE_US = 100;
  localparam int WAKE_CYCLES = STANDBY_WAKE_US * CLK_MHZ;
  localparam int SIGN_BIT = 13;
  localparam int FIFO_DEPTH = 16;
  // interface strap codes {interface_select, byte_mode_select}
  localparam logic [1:0] IF_PARALLEL = 2'h0;
  localparam logic [1:0] IF_SERIAL = 2'h2;
  localparam logic [1:0] IF_BYTE = 2'h3;
  localparam logic [CHAN_IDX_BITS-1:0] CHAN_FIRST = 3'h0;
  localparam logic [CHAN_IDX_BITS-1:0] CHAN_LAST = 3'h7;
  localparam logic [3:0] SPLIT_FIRST = 4'h0;
  localparam logic [3:0] SPLIT_SECOND = 4'h4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CONV = 4'b0010,
    ST_WAKE = 4'b0100,
    ST_DOWN = 4'b1000
  } conv_state_t;

  typedef enum logic [2:0] {
    PWR_NORMAL = 3'b001,
    PWR_STANDBY = 3'b010,
    PWR_SHUTDOWN = 3'b100
  } power_mode_t;
endpackage : simsample_pkg

// [tb/host_model.sv]
// host-side model: sample triggers, select, strobe and bus capture
`timescale 1ns/100ps

module host_model (
  // clock
  input wire logic mclk,
  // device bus
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  // host pins
  output logic trig_a,
  output logic trig_b,
  output logic cs_n,
  output logic rd_n
);
  logic [15:0] last_seen = 16'h0000;
  logic [15:0] bus_line;

  // a released bus must not look like a stale copy of the last word
  assign bus_line = data_oe ? data_out : ~last_seen;

  initial {trig_a, trig_b, cs_n, rd_n} = 4'h3;

  task automatic set_trig(input logic a, input logic b);
    @(posedge mclk);
    trig_a <= a;
    trig_b <= b;
  endtask : set_trig

  task automatic select(input logic level);
    @(posedge mclk);
    cs_n <= level;
  endtask : select

  task automatic strobe(input logic level);
    @(posedge mclk);
    rd_n <= level;
  endtask : strobe

  // one strobe, held until the word is taken
  task automatic read(input logic tied, output logic [15:0] word, output logic oe);
    @(posedge mclk);
    rd_n <= 1'b0;
    if (tied) cs_n <= 1'b0;
    repeat (6) @(posedge mclk);
    word = bus_line;
    oe = data_oe;
    last_seen <= bus_line;
    rd_n <= 1'b1;
    if (tied) cs_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : read
endmodule : host_model

// [tb/simsample_adc_conv_parallel_read_tb.sv]
// self-checking bench for the converter control block, fifo exercised through the top
`timescale 1ns/100ps

module simsample_adc_conv_parallel_read_tb;
  import simsample_pkg::*;
  localparam int CONV_T = 20;
  localparam int WAKE_T = 50;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic low_power_request_n = 1'b1;
  logic range_select = 1'b1;
  logic interface_select = 1'b0;
  logic byte_mode_select = 1'b0;
  logic [111:0] core_samples = '0;
  logic trig_a, trig_b, cs_n, rd_n;
  logic busy, parallel_mode, serial_mode, byte_mode, parallel_data_oe;
  logic [7:0] hold_channels;
  power_mode_t power_mode;
  logic [15:0] parallel_data_out, w;
  logic oe;
  int fail_count = 0;
  int checks = 0;
  int n;

  always #2 mclk = ~mclk;

  simsample_adc_conv_parallel_read #(.CONV_COUNT(CONV_T), .WAKE_COUNT(WAKE_T)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .low_power_request_n(low_power_request_n),
    .range_select(range_select), .sample_trigger_a(trig_a), .sample_trigger_b(trig_b),
    .interface_select(interface_select), .byte_mode_select(byte_mode_select),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .core_samples(core_samples),
    .busy(busy), .hold_channels(hold_channels), .power_mode(power_mode),
    .parallel_mode(parallel_mode), .serial_mode(serial_mode), .byte_mode(byte_mode),
    .parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe));

  host_model host (
    .mclk(mclk), .data_out(parallel_data_out), .data_oe(parallel_data_oe),
    .trig_a(trig_a), .trig_b(trig_b), .cs_n(cs_n), .rd_n(rd_n));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_flag

  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  function automatic logic [13:0] smp(input int ch, input logic [13:0] base);
    return base + 14'(ch) * 14'h0925;
  endfunction : smp

  // a 14-bit result as it stands on the 16-bit bus
  function automatic logic [15:0] sx(input logic [13:0] v);
    return {{2{v[13]}}, v};
  endfunction : sx

  task automatic tick(input int cycles);
    repeat (cycles) @(posedge mclk);
    #1;
  endtask : tick

  task automatic load(input logic [13:0] base);
    @(posedge mclk);
    for (int c = 0; c < 8; c++) core_samples[c*14 +: 14] <= smp(c, base);
  endtask : load

  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    tick(2);
  endtask : do_reset

  // waits for busy to reach a level, bounded
  task automatic wait_busy(input logic level);
    n = 0;
    while (busy !== level && n < 40) begin
      tick(1);
      n++;
    end
    cmp_flag("busy", level, busy);
  endtask : wait_busy

  task automatic read_all(input logic tied, input logic [13:0] lo, input logic [13:0] hi);
    for (int c = 0; c < 8; c++) begin
      host.read(tied, w, oe);
      cmp_word("data", sx(smp(c, c < 4 ? lo : hi)), w);
      cmp_flag("oe_during_read", 1'b1, oe);
      cmp_flag("oe_after_read", 1'b0, parallel_data_oe);
    end
  endtask : read_all

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_straps();
    logic [1:0] codes [3] = '{IF_SERIAL, IF_BYTE, IF_PARALLEL};
    foreach (codes[i]) begin
      @(posedge mclk);
      {interface_select, byte_mode_select} <= codes[i];
      do_reset();
      cmp_flag("parallel", codes[i] == IF_PARALLEL, parallel_mode);
      cmp_flag("serial", codes[i] == IF_SERIAL, serial_mode);
      cmp_flag("byte", codes[i] == IF_BYTE, byte_mode);
      cmp_flag("busy_reset", 1'b0, busy);
      host.read(1'b1, w, oe);
      cmp_flag("oe_mode", codes[i] == IF_PARALLEL, oe);
    end
  endtask : t_straps

  task automatic t_common();
    load(14'h2155);
    host.set_trig(1'b1, 1'b1);
    wait_busy(1'b1);
    cmp_word("hold", 16'h00ff, {8'h00, hold_channels});
    n = 0;
    while (busy === 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    cmp_word("busy_len", 16'(CONV_T), 16'(n));
    cmp_word("hold_off", 16'h0000, {8'h00, hold_channels});
    host.set_trig(1'b0, 1'b0);
    tick(12);
    host.select(1'b0);
    read_all(1'b0, 14'h2155, 14'h2155);
    host.read(1'b0, w, oe);
    cmp_word("wrap", {2'h0, smp(0, 14'h2155)} | 16'hc000, w);
    host.select(1'b1);
  endtask : t_common

  task automatic t_prev_then_tied();
    load(14'h0a0a);
    host.set_trig(1'b1, 1'b1);
    wait_busy(1'b1);
    host.read(1'b1, w, oe);
    cmp_word("old_data", {2'h3, smp(1, 14'h2155)}, w);
    wait_busy(1'b0);
    host.set_trig(1'b0, 1'b0);
    tick(12);
    read_all(1'b1, 14'h0a0a, 14'h0a0a);
  endtask : t_prev_then_tied

  task automatic t_split();
    load(14'h1234);
    host.set_trig(1'b1, 1'b0);
    tick(8);
    cmp_word("hold_a", 16'h000f, {8'h00, hold_channels});
    cmp_flag("busy_a", 1'b0, busy);
    load(14'h3c01);
    tick(3);
    host.set_trig(1'b1, 1'b1);
    wait_busy(1'b1);
    cmp_word("hold_b", 16'h00ff, {8'h00, hold_channels});
    wait_busy(1'b0);
    host.set_trig(1'b0, 1'b0);
    tick(12);
    host.select(1'b0);
    read_all(1'b0, 14'h1234, 14'h3c01);
    host.select(1'b1);
  endtask : t_split

  task automatic t_cs_edge();
    host.select(1'b0);
    host.strobe(1'b0);
    tick(4);
    cmp_flag("oe_on", 1'b1, parallel_data_oe);
    host.select(1'b1);
    tick(4);
    cmp_flag("oe_cs_rise", 1'b0, parallel_data_oe);
    host.select(1'b0);
    tick(4);
    cmp_flag("oe_cs_fall", 1'b1, parallel_data_oe);
    host.strobe(1'b1);
    host.select(1'b1);
    tick(4);
  endtask : t_cs_edge

  task automatic t_power();
    @(posedge mclk);
    low_power_request_n <= 1'b0;
    tick(4);
    cmp_word("mode_low_power_request_n", 16'(PWR_STANDBY), 16'(power_mode));
    host.read(1'b1, w, oe);
    cmp_flag("oe_down", 1'b0, oe);
    range_select <= 1'b0;
    tick(4);
    cmp_word("mode_shut", 16'(PWR_SHUTDOWN), 16'(power_mode));
    @(posedge mclk);
    low_power_request_n <= 1'b1;
    range_select <= 1'b1;
    tick(4);
    cmp_word("mode_norm", 16'(PWR_NORMAL), 16'(power_mode));
    host.set_trig(1'b1, 1'b1);
    tick(6);
    cmp_flag("busy_wake", 1'b0, busy);
    host.set_trig(1'b0, 1'b0);
    tick(WAKE_T + 10);
    do_reset();
    host.set_trig(1'b1, 1'b1);
    wait_busy(1'b1);
    wait_busy(1'b0);
    host.set_trig(1'b0, 1'b0);
  endtask : t_power

  task automatic t_fifo();
    load(14'h1f00);
    host.set_trig(1'b1, 1'b1);
    wait_busy(1'b1);
    wait_busy(1'b0);
    // retrigger at once: the next set is queued while this one still drains
    load(14'h05a5);
    host.set_trig(1'b0, 1'b0);
    host.set_trig(1'b1, 1'b1);
    wait_busy(1'b1);
    host.read(1'b1, w, oe);
    cmp_word("fifo_fill", sx(smp(0, 14'h1f00)), w);
    host.read(1'b1, w, oe);
    cmp_word("fifo_data", sx(smp(1, 14'h1f00)), w);
    wait_busy(1'b0);
    host.set_trig(1'b0, 1'b0);
    tick(12);
    read_all(1'b1, 14'h05a5, 14'h05a5);
    host.read(1'b1, w, oe);
    cmp_word("fifo_drain", sx(smp(0, 14'h05a5)), w);
  endtask : t_fifo

  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    t_straps();
    t_common();
    t_prev_then_tied();
    t_split();
    t_cs_edge();
    t_power();
    t_fifo();
    tally_and_finish();
  end
endmodule : simsample_adc_conv_parallel_read_tb
